// ---- rtl/lar_chan_integ.sv ----
`timescale 1ns/1ps
// ****************************************
// one photodiode pulse integrator
// ****************************************
module lar_chan_integ (
    // clock and reset
    input  wire logic                       clk_sys_i,
    input  wire logic                       reset_i,
    // front end pin
    input  wire logic                       pulse_pin_i,
    // sequencer control
    input  wire logic                       run_i,
    input  wire logic                       clear_i,
    input  wire logic                       gain_hi_i,
    // result
    output logic [lar_pkg::DATA_W-1:0]      count_o
);
    import lar_pkg::*;

    logic [2:0]        sync_q, sync_d;     // three-stage pin synchroniser
    logic              level_q, level_d;   // agreed pin level
    logic [DATA_W-1:0] cnt_q, cnt_d;       // running count
    logic              edge_w;             // agreed rising edge

    // next values: only stages two and three are compared
    always_comb begin
        sync_d  = {sync_q[1:0], pulse_pin_i};
        level_d = level_q;
        if (sync_q[1] == sync_q[2]) begin
            level_d = sync_q[2];
        end
        edge_w = sync_q[1] & sync_q[2] & ~level_q;
        cnt_d  = cnt_q;
        if (clear_i) begin
            cnt_d = '0;
        end else if (run_i && edge_w) begin
            cnt_d = sat_add16(cnt_q, gain_hi_i ? STEP_HI : STEP_LO);
        end
    end

    // registers
    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            sync_q  <= 3'h0;
            level_q <= 1'b0;
            cnt_q   <= 16'h0000;
        end else begin
            sync_q  <= sync_d;
            level_q <= level_d;
            cnt_q   <= cnt_d;
        end
    end

    assign count_o = cnt_q;

    // gain scales each counted edge
    gain_step_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        (run_i && !clear_i && edge_w && gain_hi_i && cnt_q < 16'hFFF0) |=> cnt_q == $past(cnt_q) + STEP_HI)
        else $error("gain step wrong");

    // count only grows while integrating
    count_mono_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        !clear_i |=> cnt_q >= $past(cnt_q))
        else $error("count went down");

endmodule

// ---- rtl/lar_persist.sv ----
`timescale 1ns/1ps
// ****************************************
// window check with persistence filter
// ****************************************
module lar_persist (
    // clock and reset
    input  wire logic        clk_sys_i,
    input  wire logic        reset_i,
    // one pulse per finished conversion
    input  wire logic        eval_i,
    input  wire logic [15:0] value_i,
    // window and persistence
    input  wire logic [15:0] lo_i,
    input  wire logic [15:0] hi_i,
    input  wire logic [3:0]  persist_i,
    // qualified event
    output logic             hit_o
);
    import lar_pkg::*;

    logic [3:0] cnt_q, cnt_d;   // consecutive outside results
    logic       out_w;          // value outside the window
    logic       reach_w;        // this one meets the persistence

    // next values
    always_comb begin
        out_w   = (value_i > hi_i) || (value_i < lo_i);
        reach_w = ({1'b0, cnt_q} + 5'h01) >= {1'b0, persist_i};
        hit_o   = eval_i & out_w & reach_w;
        cnt_d   = cnt_q;
        if (eval_i) begin
            // saturate once reached, drop to zero back in the window
            cnt_d = out_w ? (reach_w ? cnt_q : cnt_q + 4'h1) : 4'h0;
        end
    end

    // registers
    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            cnt_q <= 4'h0;
        end else begin
            cnt_q <= cnt_d;
        end
    end

    // an event needs enough earlier outside results
    persist_hold_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        (hit_o && persist_i > 4'h1) |-> cnt_q >= persist_i - 4'h1)
        else $error("event before persistence");

endmodule

// ---- rtl/lar_top.sv ----
// Chosen here: the AHB-Lite interface to the registers and the register addresses.
`timescale 1ns/1ps
// How it works
// - both channels integrate and stop together
// - finished results go to their data registers
// - each result reads as sixteen bits
// - results are double-buffered, never mixed
// - next integration starts by itself
// - broadband result outside upper or lower limit raises interrupt
// - persistence filters short excursions
// - level mode holds until host clears
// - alert mode clears when status is read
// - interrupt pin is open-drain, pulls low
// - gain and integration time are programmable
// - host bus pace up to fast mode
module lar_top #(
    parameter int unsigned SHORT_US = lar_pkg::INTEG_SHORT_US, // 13.7 ms
    parameter int unsigned MID_US   = lar_pkg::INTEG_MID_US,   // 101 ms
    parameter int unsigned LONG_US  = lar_pkg::INTEG_LONG_US   // 402 ms
) (
    // clock and reset
    input  wire logic        clk_sys_i,
    input  wire logic        reset_i,
    // ahb-lite slave
    input  wire logic        hsel_i,
    input  wire logic [31:0] haddr_i,
    input  wire logic [1:0]  htrans_i,
    input  wire logic        hwrite_i,
    input  wire logic [2:0]  hsize_i,
    input  wire logic [31:0] hwdata_i,
    input  wire logic        hready_i,
    output logic      [31:0] hrdata_o,
    output logic             hreadyout_o,
    output logic             hresp_o,
    // photodiode front end pulses
    input  wire logic        bb_pulse_i,
    input  wire logic        ir_pulse_i,
    // open-drain interrupt pin
    output logic             int_pin_o,
    output logic             int_pin_oe_n_o
);
    import lar_pkg::*;

    // ****************************************
    // declarations
    // ****************************************
    logic [31:0]   ctrl_q, ctrl_d;          // control word
    logic [15:0]   thr_lo_q, thr_lo_d;      // lower limit
    logic [15:0]   thr_hi_q, thr_hi_d;      // upper limit
    logic          wr_pend_q, wr_pend_d;    // write data phase due
    logic [7:0]    wr_addr_q, wr_addr_d;    // its address
    logic [31:0]   rdata_q, rdata_d;        // read data phase word
    logic          acc_w;                   // address phase taken
    logic          stat_rd_w;               // status read taken
    logic          clr_wr_w;                // clear written
    lar_state_type state_q, state_d;        // sequencer
    logic [6:0]    div_q, div_d;            // tick divider
    logic          tick_w;                  // one-microsecond enable
    logic [19:0]   us_q, us_d;              // elapsed microseconds
    logic [19:0]   limit_w;                 // selected window
    logic [15:0]   bb_data_q, bb_data_d;    // broadband result
    logic [15:0]   ir_data_q, ir_data_d;    // infrared result
    logic          valid_q, valid_d;        // a result exists
    logic          pend_q, pend_d;          // interrupt pending
    logic [15:0]   bb_cnt_w;                // live broadband count
    logic [15:0]   ir_cnt_w;                // live infrared count
    logic          run_w;                   // integrating
    logic          xfer_w;                  // transfer cycle
    logic          hit_w;                   // qualified event
    logic          en_w;                    // converter enabled
    logic          alert_w;                 // alert style selected

    assign en_w    = ctrl_q[CTRL_EN_BIT];
    assign alert_w = ctrl_q[CTRL_ALERT_BIT];

    // ****************************************
    // bus slave
    // ****************************************
    assign acc_w     = hsel_i & htrans_i[1] & hready_i;
    assign stat_rd_w = acc_w & ~hwrite_i & (haddr_i[7:0] == REG_STATUS);
    assign clr_wr_w  = wr_pend_q & (wr_addr_q == REG_INT_CLR) & hwdata_i[INT_CLR_BIT];

    // read word for an offset, zero where unmapped
    function automatic logic [31:0] rd_word(input logic [7:0] a);
        case (a)
            REG_CTRL:    rd_word = ctrl_q;
            REG_THR_LO:  rd_word = {16'h0000, thr_lo_q};
            REG_THR_HI:  rd_word = {16'h0000, thr_hi_q};
            REG_STATUS:  rd_word = {29'h0000_0000, run_w, valid_q, pend_q};
            REG_BB_DATA: rd_word = {16'h0000, bb_data_q};
            REG_IR_DATA: rd_word = {16'h0000, ir_data_q};
            REG_BOTH:    rd_word = {ir_data_q, bb_data_q};
            default:     rd_word = 32'h0000_0000;
        endcase
    endfunction

    // next values for bus and register file
    always_comb begin
        wr_pend_d = acc_w & hwrite_i;
        wr_addr_d = acc_w ? haddr_i[7:0] : wr_addr_q;
        // read data captured at the address phase edge
        rdata_d   = (acc_w && !hwrite_i) ? rd_word(haddr_i[7:0]) : 32'h0000_0000;
        ctrl_d    = ctrl_q;
        thr_lo_d  = thr_lo_q;
        thr_hi_d  = thr_hi_q;
        if (wr_pend_q) begin
            case (wr_addr_q)
                REG_CTRL: begin
                    ctrl_d = hwdata_i;
                end
                REG_THR_LO: begin
                    thr_lo_d = hwdata_i[15:0];
                end
                REG_THR_HI: begin
                    thr_hi_d = hwdata_i[15:0];
                end
                default: begin
                    // read-only or unmapped: dropped
                end
            endcase
        end
    end

    // bus registers
    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            wr_pend_q <= 1'b0;
            wr_addr_q <= 8'h00;
            rdata_q   <= 32'h0000_0000;
            ctrl_q    <= CTRL_RST;
            thr_lo_q  <= THR_LO_RST;
            thr_hi_q  <= THR_HI_RST;
        end else begin
            wr_pend_q <= wr_pend_d;
            wr_addr_q <= wr_addr_d;
            rdata_q   <= rdata_d;
            ctrl_q    <= ctrl_d;
            thr_lo_q  <= thr_lo_d;
            thr_hi_q  <= thr_hi_d;
        end
    end

    assign hrdata_o    = rdata_q;
    // never stalls, so the host's own serial pace stays the only limit
    assign hreadyout_o = 1'b1;
    assign hresp_o     = 1'b0;

    // ****************************************
    // conversion sequencer
    // ****************************************
    assign tick_w  = (div_q == 7'(TICK_CYC - 1));
    assign run_w   = (state_q == LAR_INTEG);
    assign xfer_w  = (state_q == LAR_XFER);

    // window length from the time select field
    always_comb begin
        case (ctrl_q[CTRL_ITIME_LSB +: 2])
            2'h0:    limit_w = 20'(SHORT_US);
            2'h1:    limit_w = 20'(MID_US);
            default: limit_w = 20'(LONG_US);
        endcase
    end

    // next sequencer values
    always_comb begin
        div_d     = tick_w ? 7'h00 : div_q + 7'h01;
        us_d      = us_q;
        state_d   = state_q;
        bb_data_d = bb_data_q;
        ir_data_d = ir_data_q;
        valid_d   = valid_q;
        case (state_q)
            LAR_IDLE: begin
                us_d = 20'h00000;
                if (en_w) begin
                    state_d = LAR_INTEG;
                end
            end
            LAR_INTEG: begin
                if (!en_w) begin
                    state_d = LAR_IDLE;
                end else if (tick_w) begin
                    us_d = us_q + 20'h00001;
                    // a shortened window still ends at the new limit
                    if (us_d >= limit_w) begin
                        state_d = LAR_XFER;
                    end
                end
            end
            LAR_XFER: begin
                // both results move in the same cycle
                bb_data_d = bb_cnt_w;
                ir_data_d = ir_cnt_w;
                valid_d   = 1'b1;
                us_d      = 20'h00000;
                state_d   = en_w ? LAR_INTEG : LAR_IDLE;
            end
            default: begin
                state_d = LAR_IDLE;
            end
        endcase
    end

    // sequencer registers
    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            state_q   <= LAR_IDLE;
            div_q     <= 7'h00;
            us_q      <= 20'h00000;
            bb_data_q <= 16'h0000;
            ir_data_q <= 16'h0000;
            valid_q   <= 1'b0;
        end else begin
            state_q   <= state_d;
            div_q     <= div_d;
            us_q      <= us_d;
            bb_data_q <= bb_data_d;
            ir_data_q <= ir_data_d;
            valid_q   <= valid_d;
        end
    end

    // ****************************************
    // channels and window check
    // ****************************************
    lar_chan_integ u_bb (
        .clk_sys_i   (clk_sys_i),
        .reset_i     (reset_i),
        .pulse_pin_i (bb_pulse_i),
        .run_i       (run_w),
        .clear_i     (~run_w),
        .gain_hi_i   (ctrl_q[CTRL_GAIN_BIT]),
        .count_o     (bb_cnt_w)
    );

    lar_chan_integ u_ir (
        .clk_sys_i   (clk_sys_i),
        .reset_i     (reset_i),
        .pulse_pin_i (ir_pulse_i),
        .run_i       (run_w),
        .clear_i     (~run_w),
        .gain_hi_i   (ctrl_q[CTRL_GAIN_BIT]),
        .count_o     (ir_cnt_w)
    );

    // judged on the broadband result as it is loaded
    lar_persist u_pers (
        .clk_sys_i (clk_sys_i),
        .reset_i   (reset_i),
        .eval_i    (xfer_w),
        .value_i   (bb_cnt_w),
        .lo_i      (thr_lo_q),
        .hi_i      (thr_hi_q),
        .persist_i (ctrl_q[CTRL_PERS_LSB +: 4]),
        .hit_o     (hit_w)
    );

    // ****************************************
    // interrupt
    // ****************************************
    // set wins over either clear so no event is lost
    always_comb begin
        pend_d = pend_q;
        if (alert_w && stat_rd_w) begin
            pend_d = 1'b0;
        end
        if (!alert_w && clr_wr_w) begin
            pend_d = 1'b0;
        end
        if (hit_w && ctrl_q[CTRL_INTEN_BIT]) begin
            pend_d = 1'b1;
        end
    end

    // interrupt register
    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            pend_q <= 1'b0;
        end else begin
            pend_q <= pend_d;
        end
    end

    // pin only ever pulls low; released otherwise
    assign int_pin_o      = 1'b0;
    assign int_pin_oe_n_o = ~pend_q;

    // ****************************************
    // checks
    // ****************************************
    sequence xfer_s;
        state_q == LAR_XFER;
    endsequence

    sequence restart_s;
        state_q == LAR_INTEG ##1 state_q == LAR_INTEG;
    endsequence

    xfer_restart_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        (xfer_s and en_w) |=> restart_s)
        else $error("no automatic restart");

    data_load_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        xfer_s |=> (bb_data_q == $past(bb_cnt_w)) && (ir_data_q == $past(ir_cnt_w)))
        else $error("result not loaded");

    data_hold_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        !$stable(bb_data_q) || !$stable(ir_data_q) |-> $past(xfer_w))
        else $error("data changed outside transfer");

    both_clear_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        xfer_s |=> (bb_cnt_w == 16'h0000) && (ir_cnt_w == 16'h0000))
        else $error("channels not restarted together");

    event_time_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        hit_w |-> xfer_w)
        else $error("event outside transfer");

    irq_cause_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        $rose(pend_q) |-> $past(hit_w && ctrl_q[CTRL_INTEN_BIT]))
        else $error("interrupt without cause");

    level_hold_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        (pend_q && !alert_w && !clr_wr_w) |=> pend_q)
        else $error("level interrupt dropped");

    alert_clear_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        (pend_q && alert_w && stat_rd_w && !hit_w) |=> !pend_q ##1 !int_pin_oe_n_o == pend_q)
        else $error("alert not cleared by status read");

    pin_drive_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        $rose(pend_q) |-> !int_pin_oe_n_o && !int_pin_o)
        else $error("pin not pulled low");

endmodule

// ---- shared/lar_pkg.sv ----
// ****************************************
// shared constants for the light readout
// ****************************************
package lar_pkg;

    // clock and time base
    localparam int CLK_NS           = 10;                  // 100 mhz system clock
    localparam int TICK_NS          = 1000;                // one microsecond tick
    localparam int TICK_CYC         = TICK_NS / CLK_NS;    // cycles per tick
    localparam int INTEG_SHORT_US   = 13700;               // 13.7 ms window
    localparam int INTEG_MID_US     = 101000;              // 101 ms window
    localparam int INTEG_LONG_US    = 402000;              // 402 ms window
    localparam int FAST_MODE_KHZ    = 400;                 // fastest host serial rate

    // data path
    localparam int          DATA_W  = 16;                  // result width
    localparam logic [15:0] STEP_HI = 16'h0010;            // 16x gain step
    localparam logic [15:0] STEP_LO = 16'h0001;            // 1x gain step

    // register byte offsets
    localparam logic [7:0] REG_CTRL    = 8'h00;
    localparam logic [7:0] REG_THR_LO  = 8'h04;
    localparam logic [7:0] REG_THR_HI  = 8'h08;
    localparam logic [7:0] REG_STATUS  = 8'h0C;
    localparam logic [7:0] REG_BB_DATA = 8'h10;
    localparam logic [7:0] REG_IR_DATA = 8'h14;
    localparam logic [7:0] REG_BOTH    = 8'h18;
    localparam logic [7:0] REG_INT_CLR = 8'h1C;

    // field positions
    localparam int CTRL_EN_BIT    = 0;
    localparam int CTRL_GAIN_BIT  = 1;
    localparam int CTRL_ITIME_LSB = 2;
    localparam int CTRL_INTEN_BIT = 4;
    localparam int CTRL_ALERT_BIT = 5;
    localparam int CTRL_PERS_LSB  = 8;
    localparam int ST_PEND_BIT    = 0;
    localparam int ST_VALID_BIT   = 1;
    localparam int ST_BUSY_BIT    = 2;
    localparam int INT_CLR_BIT    = 0;

    // reset values
    localparam logic [31:0] CTRL_RST   = 32'h0000_0000;
    localparam logic [15:0] THR_LO_RST = 16'h0000;
    localparam logic [15:0] THR_HI_RST = 16'hFFFF;

    // conversion sequencer states
    typedef enum logic [1:0] {LAR_IDLE, LAR_INTEG, LAR_XFER} lar_state_type;

    // add with clamp at full scale
    function automatic logic [15:0] sat_add16(input logic [15:0] a, input logic [15:0] b);
        logic [16:0] s;
        s = {1'b0, a} + {1'b0, b};
        sat_add16 = s[16] ? 16'hFFFF : s[15:0];
    endfunction

endpackage

// ---- verif/dual_channel_light_adc_readout_tb.sv ----
`timescale 1ns/1ps
// ****************************************
// register level bench of the light readout
// ****************************************
module dual_channel_light_adc_readout_tb;
    import lar_pkg::*;
    logic clk_sys_i = 1'b0, reset_i = 1'b1, hsel_i = 1'b1, hwrite_i = 1'b0, go = 1'b0;
    logic [31:0] haddr_i = 32'h0, hwdata_i = 32'h0, hrdata_o, rd;
    logic [1:0]  htrans_i = 2'h0;
    logic [2:0]  hsize_i = 3'h2;
    logic [7:0]  bb_n = 8'h0, ir_n = 8'h0;
    logic        hreadyout_o, hresp_o, bb_pulse, ir_pulse, int_pin_o, int_pin_oe_n_o;
    int          miscompares = 0, cmp_count = 0, t0;
    wire         int_line = int_pin_oe_n_o ? 1'b1 : int_pin_o; // pull-up on the pin

    always #5 clk_sys_i = ~clk_sys_i;

    // short windows keep each conversion a few hundred cycles
    lar_top #(.SHORT_US(3), .MID_US(5), .LONG_US(8)) i_lar_top (
        .clk_sys_i(clk_sys_i), .reset_i(reset_i), .hsel_i(hsel_i), .haddr_i(haddr_i),
        .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hsize_i(hsize_i), .hwdata_i(hwdata_i),
        .hready_i(hreadyout_o), .hrdata_o(hrdata_o), .hreadyout_o(hreadyout_o), .hresp_o(hresp_o),
        .bb_pulse_i(bb_pulse), .ir_pulse_i(ir_pulse), .int_pin_o(int_pin_o), .int_pin_oe_n_o(int_pin_oe_n_o));
    lar_pulse_src i_lar_pulse_src (.clk_sys_i(clk_sys_i), .go_i(go), .bb_n_i(bb_n), .ir_n_i(ir_n),
        .bb_o(bb_pulse), .ir_o(ir_pulse));

    task automatic wrap_up();
        $display("comparisons %0d, miscompares %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            miscompares++;
            $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    // one single transfer; address held until hready, data held until hready
    task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        htrans_i <= 2'h2;
        haddr_i  <= {24'h0, a};
        hwrite_i <= wr;
        do @(posedge clk_sys_i); while (hreadyout_o !== 1'b1);
        htrans_i <= 2'h0;
        hwdata_i <= wd;
        do @(posedge clk_sys_i); while (hreadyout_o !== 1'b1);
        rd = hrdata_o;
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] mask, input logic [31:0] exp);
        xfer(1'b0, a, 32'h0);
        check(rd & mask, exp);
        check({31'h0, hresp_o}, 32'h0);
    endtask

    task automatic do_reset();
        reset_i <= 1'b1;
        repeat (6) @(posedge clk_sys_i);
        reset_i <= 1'b0;
        @(posedge clk_sys_i);
    endtask

    task automatic fire(input logic [7:0] nb, input logic [7:0] ni);
        bb_n <= nb;
        ir_n <= ni;
        go   <= 1'b1;
        @(posedge clk_sys_i);
        go   <= 1'b0;
    endtask

    // poll until a status bit rises; the watchdog bounds a hang
    task automatic wait_status(input int bit_no);
        do xfer(1'b0, REG_STATUS, 32'h0); while (rd[bit_no] !== 1'b1);
    endtask

    task automatic wait_pin_low();
        t0 = 0;
        while (int_line !== 1'b0 && t0 < 3000) begin
            @(posedge clk_sys_i);
            t0++;
        end
    endtask

    initial begin
        repeat (50000) @(posedge clk_sys_i);
        miscompares++;
        wrap_up();
    end

    initial begin
        do_reset();
        // reset values, unmapped place, idle pin
        rd_chk(REG_CTRL, 32'hFFFFFFFF, CTRL_RST);
        rd_chk(REG_THR_LO, 32'hFFFFFFFF, {16'h0, THR_LO_RST});
        rd_chk(REG_THR_HI, 32'hFFFFFFFF, {16'h0, THR_HI_RST});
        rd_chk(REG_STATUS, 32'hFFFFFFFF, 32'h0);
        rd_chk(8'h20, 32'hFFFFFFFF, 32'h0);
        check({31'h0, int_line}, 32'h1);
        // unity gain, short window, both channels in one conversion
        xfer(1'b1, REG_CTRL, 32'h0000_0001);
        fire(8'h05, 8'h03);
        wait_status(ST_VALID_BIT);
        rd_chk(REG_BB_DATA, 32'hFFFFFFFF, 32'h5);
        rd_chk(REG_IR_DATA, 32'hFFFFFFFF, 32'h3);
        rd_chk(REG_BOTH, 32'hFFFFFFFF, 32'h0003_0005);
        // next window runs with no host action
        fire(8'h02, 8'h04);
        t0 = 0;
        do begin
            xfer(1'b0, REG_BB_DATA, 32'h0);
            t0++;
        end while (rd === 32'h5 && t0 < 400);
        rd_chk(REG_BOTH, 32'hFFFFFFFF, 32'h0004_0002);
        // high gain, middle window
        do_reset();
        xfer(1'b1, REG_CTRL, 32'h0000_0007);
        rd_chk(REG_CTRL, 32'hFFFFFFFF, 32'h7);
        fire(8'h02, 8'h01);
        wait_status(ST_VALID_BIT);
        rd_chk(REG_BOTH, 32'hFFFFFFFF, 32'h0010_0020);
        // level interrupt above the upper limit
        do_reset();
        xfer(1'b1, REG_THR_HI, 32'h4);
        xfer(1'b1, REG_CTRL, 32'h0000_0011);
        fire(8'h06, 8'h00);
        wait_pin_low();
        check({31'h0, int_line}, 32'h0);
        rd_chk(REG_STATUS, 32'h1, 32'h1);
        check({31'h0, int_line}, 32'h0);
        xfer(1'b1, REG_INT_CLR, 32'h1);
        // the clear lands at the data phase edge; look once it has settled
        @(posedge clk_sys_i);
        check({31'h0, int_line}, 32'h1);
        // alert interrupt below the lower limit, cleared by status read
        do_reset();
        xfer(1'b1, REG_THR_LO, 32'h3);
        xfer(1'b1, REG_CTRL, 32'h0000_0031);
        wait_pin_low();
        check({31'h0, int_line}, 32'h0);
        xfer(1'b1, REG_INT_CLR, 32'h1);
        // a level clear would show one edge later, so wait for it
        @(posedge clk_sys_i);
        check({31'h0, int_line}, 32'h0);
        rd_chk(REG_STATUS, 32'h1, 32'h1);
        check({31'h0, int_line}, 32'h1);
        // long window: first event only after eight ticks
        do_reset();
        xfer(1'b1, REG_THR_LO, 32'h3);
        xfer(1'b1, REG_CTRL, 32'h0000_0019);
        wait_pin_low();
        check({31'h0, (t0 > 650 && t0 < 900)}, 32'h1);
        // persistence of three: the first two outside results stay silent
        do_reset();
        xfer(1'b1, REG_THR_LO, 32'h3);
        xfer(1'b1, REG_CTRL, 32'h0000_0311);
        wait_pin_low();
        check({31'h0, (t0 > 650 && t0 < 1100)}, 32'h1);
        wrap_up();
    end
endmodule

// ---- verif/lar_pulse_src.sv ----
`timescale 1ns/1ps
// ****************************************
// photodiode front end stand-in
// ****************************************
module lar_pulse_src (
    // clock and burst request
    input  wire logic       clk_sys_i,
    input  wire logic       go_i,
    input  wire logic [7:0] bb_n_i,
    input  wire logic [7:0] ir_n_i,
    // pulse pins
    output logic            bb_o,
    output logic            ir_o
);
    int bb_left = 0; // broadband pulses still to send
    int ir_left = 0; // infrared pulses still to send
    int ph      = 0; // phase in a six cycle pulse slot

    // three high, three low: slow enough that the front end sampler misses none
    always @(posedge clk_sys_i) begin
        if (go_i) begin
            bb_left <= bb_n_i;
            ir_left <= ir_n_i;
            ph      <= 0;
        end else begin
            ph <= (ph == 5) ? 0 : ph + 1;
            if (ph == 5 && bb_left > 0) bb_left <= bb_left - 1;
            if (ph == 5 && ir_left > 0) ir_left <= ir_left - 1;
        end
    end
    // pins idle low between bursts
    assign bb_o = (bb_left > 0) && (ph < 3);
    assign ir_o = (ir_left > 0) && (ph < 3);
endmodule
